/* rtl/dual_legacy_counter_timers.sv */
`timescale 1ns/1ns
module dual_legacy_counter_timers (
	input  wire logic                           sys_clk_i,
	input  wire logic                           rst_b_i,
	input  wire logic [timer01_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [timer01_pkg::DATA_W-1:0] reg_wr_data_i,
	input  wire logic                           reg_wr_i,
	input  wire logic                           reg_rd_i,
	output logic      [timer01_pkg::DATA_W-1:0] reg_rd_data_o,
	input  wire logic                           timer0_count_pin_i,
	input  wire logic                           timer1_count_pin_i,
	input  wire logic                           ext_irq_input_a_i,
	input  wire logic                           ext_irq_input_b_i,
	input  wire logic                           ext_osc_i,
	output logic                                timer0_irq_o,
	output logic                                timer1_irq_o,
	output logic                                timer0_overflow_pulse_o,
	output logic                                timer1_overflow_pulse_o
);

	// ------------------------------------------------------------
	// software registers and registered outputs
	// ------------------------------------------------------------
	logic [7:0] timer_clock_select_r;
	logic [7:0] timer01_control_reg_r;
	logic [7:0] timer01_mode_reg_r;
	logic [7:0] timer0_lower_byte_r;
	logic [7:0] timer0_upper_byte_r;
	logic [7:0] timer1_lower_byte_r;
	logic [7:0] timer1_upper_byte_r;
	logic [7:0] ext_irq_config_reg_r;
	logic [7:0] interrupt_enable_reg_r;
	logic [7:0] rd_data_r;
	logic       timer0_irq_r;
	logic       timer1_irq_r;
	logic       timer0_pulse_r;
	logic       timer1_pulse_r;

	// next values
	logic [7:0] timer_clock_select_nxt;
	logic [7:0] timer01_control_reg_nxt;
	logic [7:0] timer01_mode_reg_nxt;
	logic [7:0] timer0_lower_byte_nxt;
	logic [7:0] timer0_upper_byte_nxt;
	logic [7:0] timer1_lower_byte_nxt;
	logic [7:0] timer1_upper_byte_nxt;
	logic [7:0] ext_irq_config_reg_nxt;
	logic [7:0] interrupt_enable_reg_nxt;
	logic [7:0] rd_data_nxt;

	// ------------------------------------------------------------
	// synchronised pins and prescaler
	// ------------------------------------------------------------
	wire        timer0_pin_fall;
	wire        timer1_pin_fall;
	wire        irq_a_level;
	wire        irq_b_level;
	wire        osc_rise;
	wire        presc_tick;

	// count pins: one pulse for every falling edge
	pin_edge_sync u_timer0_pin (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.pin_i     (timer0_count_pin_i),
		.level_o   (),
		.fall_o    (timer0_pin_fall),
		.rise_o    ()
	);

	pin_edge_sync u_timer1_pin (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.pin_i     (timer1_count_pin_i),
		.level_o   (),
		.fall_o    (timer1_pin_fall),
		.rise_o    ()
	);

	// gating inputs: only the settled level is used
	pin_edge_sync u_irq_a (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.pin_i     (ext_irq_input_a_i),
		.level_o   (irq_a_level),
		.fall_o    (),
		.rise_o    ()
	);

	pin_edge_sync u_irq_b (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.pin_i     (ext_irq_input_b_i),
		.level_o   (irq_b_level),
		.fall_o    (),
		.rise_o    ()
	);

	// oscillator must run below half the system clock to be counted
	pin_edge_sync u_osc (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.pin_i     (ext_osc_i),
		.level_o   (),
		.fall_o    (),
		.rise_o    (osc_rise)
	);

	timer_prescaler #(
		.CNT_W (6)
	) u_prescaler (
		.sys_clk_i  (sys_clk_i),
		.rst_b_i    (rst_b_i),
		.div_sel_i  (timer_clock_select_r[timer01_pkg::DIV_SEL_LSB +: 2]),
		.osc_edge_i (osc_rise),
		.tick_o     (presc_tick)
	);

	// ------------------------------------------------------------
	// one count step: {overflow, upper byte, lower byte}
	// ------------------------------------------------------------
	function automatic logic [16:0] count_step(
		input logic [1:0] mode,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		begin
			s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
			s16 = {1'b0, hi, lo} + 17'h00001;
			s8  = {1'b0, lo} + 9'h001;
			case (mode)
				timer01_pkg::MODE_13BIT: begin
					// unused low bits 7:5 just hold
					count_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
				end
				timer01_pkg::MODE_16BIT: begin
					count_step = s16;
				end
				timer01_pkg::MODE_RELOAD: begin
					count_step = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
				end
				default: begin
					count_step = {s8[8], hi, s8[7:0]};
				end
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	wire [1:0]  timer0_mode;
	wire [1:0]  timer1_mode;
	wire        timer0_split;
	wire        timer1_parked;
	wire        timer0_run_bit;
	wire        timer1_run_bit;
	wire        timer0_edge_count_select;
	wire        timer1_edge_count_select;
	wire        timer0_pin_gating;
	wire        timer1_pin_gating;

	assign timer0_mode              = timer01_mode_reg_r[timer01_pkg::T0_MODE_LSB +: 2];
	assign timer1_mode              = timer01_mode_reg_r[timer01_pkg::T1_MODE_LSB +: 2];
	assign timer0_split             = (timer0_mode == timer01_pkg::MODE_SPLIT);
	assign timer1_parked            = (timer1_mode == timer01_pkg::MODE_SPLIT);
	assign timer0_run_bit           = timer01_control_reg_r[timer01_pkg::BIT_T0_RUN];
	assign timer1_run_bit           = timer01_control_reg_r[timer01_pkg::BIT_T1_RUN];
	assign timer0_edge_count_select = timer01_mode_reg_r[timer01_pkg::BIT_T0_EDGE];
	assign timer1_edge_count_select = timer01_mode_reg_r[timer01_pkg::BIT_T1_EDGE];
	assign timer0_pin_gating        = timer01_mode_reg_r[timer01_pkg::BIT_T0_GATING];
	assign timer1_pin_gating        = timer01_mode_reg_r[timer01_pkg::BIT_T1_GATING];

	// ------------------------------------------------------------
	// clock choice and run gating
	// ------------------------------------------------------------
	wire        timer0_base_tick;
	wire        timer1_base_tick;
	wire        irq_a_active;
	wire        irq_b_active;
	wire        timer0_gate_ok;
	wire        timer1_gate_ok;
	wire        timer0_en;
	wire        timer1_plain_en;
	wire        timer1_en;
	wire        upper0_split_en;

	// internal tick: system clock every cycle, else the prescaler tick
	assign timer0_base_tick = timer_clock_select_r[timer01_pkg::BIT_T0_SYSCLK] ? 1'b1 : presc_tick;
	assign timer1_base_tick = timer_clock_select_r[timer01_pkg::BIT_T1_SYSCLK] ? 1'b1 : presc_tick;

	// polarity bit 1 means the input is active high
	assign irq_a_active     = (irq_a_level == ext_irq_config_reg_r[timer01_pkg::BIT_IRQ_A_POL]);
	assign irq_b_active     = (irq_b_level == ext_irq_config_reg_r[timer01_pkg::BIT_IRQ_B_POL]);
	assign timer0_gate_ok   = ~timer0_pin_gating | irq_a_active;
	assign timer1_gate_ok   = ~timer1_pin_gating | irq_b_active;

	// edge select overrides the clock select bit entirely
	assign timer0_en        = timer0_run_bit & timer0_gate_ok &
	                          (timer0_edge_count_select ? timer0_pin_fall : timer0_base_tick);
	assign timer1_plain_en  = timer1_run_bit & timer1_gate_ok &
	                          (timer1_edge_count_select ? timer1_pin_fall : timer1_base_tick);

	// with timer 0 split, timer 1 runs on its mode alone, internal clock only
	assign timer1_en        = ~timer1_parked &
	                          (timer0_split ? timer1_base_tick : timer1_plain_en);
	// split upper byte: internal clock, timer 1 run bit, no gating
	assign upper0_split_en  = timer0_split & timer1_run_bit & timer0_base_tick;

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	wire [16:0] timer0_step;
	wire [16:0] timer1_step;
	wire [8:0]  upper0_sum;
	wire        timer0_ovf;
	wire        timer1_ovf;
	wire        upper0_ovf;
	wire        timer0_flag_set;
	wire        timer1_flag_set;

	assign timer0_step     = count_step(timer0_mode, timer0_lower_byte_r, timer0_upper_byte_r);
	assign timer1_step     = count_step(timer1_mode, timer1_lower_byte_r, timer1_upper_byte_r);
	assign upper0_sum      = {1'b0, timer0_upper_byte_r} + 9'h001;
	assign timer0_ovf      = timer0_en & timer0_step[16];
	assign timer1_ovf      = timer1_en & timer1_step[16];
	assign upper0_ovf      = upper0_split_en & upper0_sum[8];
	assign timer0_flag_set = timer0_ovf;
	// split mode hands timer 1's flag to timer 0's upper byte
	assign timer1_flag_set = timer0_split ? upper0_ovf : timer1_ovf;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire        wr_clock_select;
	wire        wr_control;
	wire        wr_mode;
	wire        wr_t0_lower;
	wire        wr_t0_upper;
	wire        wr_t1_lower;
	wire        wr_t1_upper;
	wire        wr_irq_config;
	wire        wr_irq_enable;

	assign wr_clock_select = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_CLOCK_SELECT);
	assign wr_control      = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_CONTROL);
	assign wr_mode         = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_MODE);
	assign wr_t0_lower     = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_T0_LOWER);
	assign wr_t0_upper     = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_T0_UPPER);
	assign wr_t1_lower     = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_T1_LOWER);
	assign wr_t1_upper     = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_T1_UPPER);
	assign wr_irq_config   = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_IRQ_CONFIG);
	assign wr_irq_enable   = reg_wr_i && (reg_addr_i == timer01_pkg::OFS_IRQ_ENABLE);

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	// configuration: stores, irq config and enable masked to their defined bits; the run bit never touches the count
	always_comb begin
		timer_clock_select_nxt   = wr_clock_select ? reg_wr_data_i : timer_clock_select_r;
		timer01_mode_reg_nxt     = wr_mode ? reg_wr_data_i : timer01_mode_reg_r;
		ext_irq_config_reg_nxt   = wr_irq_config ?
		                           (reg_wr_data_i & timer01_pkg::IRQ_CONFIG_MASK) :
		                           ext_irq_config_reg_r;
		interrupt_enable_reg_nxt = wr_irq_enable ?
		                           (reg_wr_data_i & timer01_pkg::IRQ_ENABLE_MASK) :
		                           interrupt_enable_reg_r;
		timer01_control_reg_nxt  = wr_control ? reg_wr_data_i : timer01_control_reg_r;
		// an overflow in the clearing cycle still sets the flag
		if (timer0_flag_set) begin
			timer01_control_reg_nxt[timer01_pkg::BIT_T0_FLAG] = 1'b1;
		end
		if (timer1_flag_set) begin
			timer01_control_reg_nxt[timer01_pkg::BIT_T1_FLAG] = 1'b1;
		end
	end

	// count bytes: a software load wins over a count in the same cycle
	always_comb begin
		timer0_lower_byte_nxt = timer0_lower_byte_r;
		timer0_upper_byte_nxt = timer0_upper_byte_r;
		timer1_lower_byte_nxt = timer1_lower_byte_r;
		timer1_upper_byte_nxt = timer1_upper_byte_r;
		if (timer0_en) begin
			timer0_lower_byte_nxt = timer0_step[7:0];
			if (!timer0_split) begin
				timer0_upper_byte_nxt = timer0_step[15:8];
			end
		end
		if (upper0_split_en) begin
			timer0_upper_byte_nxt = upper0_sum[7:0];
		end
		if (timer1_en) begin
			timer1_lower_byte_nxt = timer1_step[7:0];
			timer1_upper_byte_nxt = timer1_step[15:8];
		end
		if (wr_t0_lower) begin
			timer0_lower_byte_nxt = reg_wr_data_i;
		end
		if (wr_t0_upper) begin
			timer0_upper_byte_nxt = reg_wr_data_i;
		end
		if (wr_t1_lower) begin
			timer1_lower_byte_nxt = reg_wr_data_i;
		end
		if (wr_t1_upper) begin
			timer1_upper_byte_nxt = reg_wr_data_i;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		if (reg_addr_i == timer01_pkg::OFS_CLOCK_SELECT) begin
			rd_data_nxt = timer_clock_select_r;
		end else if (reg_addr_i == timer01_pkg::OFS_CONTROL) begin
			rd_data_nxt = timer01_control_reg_r;
		end else if (reg_addr_i == timer01_pkg::OFS_MODE) begin
			rd_data_nxt = timer01_mode_reg_r;
		end else if (reg_addr_i == timer01_pkg::OFS_T0_LOWER) begin
			rd_data_nxt = timer0_lower_byte_r;
		end else if (reg_addr_i == timer01_pkg::OFS_T0_UPPER) begin
			rd_data_nxt = timer0_upper_byte_r;
		end else if (reg_addr_i == timer01_pkg::OFS_T1_LOWER) begin
			rd_data_nxt = timer1_lower_byte_r;
		end else if (reg_addr_i == timer01_pkg::OFS_T1_UPPER) begin
			rd_data_nxt = timer1_upper_byte_r;
		end else if (reg_addr_i == timer01_pkg::OFS_IRQ_CONFIG) begin
			rd_data_nxt = ext_irq_config_reg_r;
		end else if (reg_addr_i == timer01_pkg::OFS_IRQ_ENABLE) begin
			rd_data_nxt = interrupt_enable_reg_r;
		end else begin
			rd_data_nxt = timer01_pkg::RST_BYTE;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// configuration and count state
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			timer_clock_select_r   <= timer01_pkg::RST_BYTE;
			timer01_control_reg_r  <= timer01_pkg::RST_BYTE;
			timer01_mode_reg_r     <= timer01_pkg::RST_BYTE;
			timer0_lower_byte_r    <= timer01_pkg::RST_BYTE;
			timer0_upper_byte_r    <= timer01_pkg::RST_BYTE;
			timer1_lower_byte_r    <= timer01_pkg::RST_BYTE;
			timer1_upper_byte_r    <= timer01_pkg::RST_BYTE;
			ext_irq_config_reg_r   <= timer01_pkg::RST_BYTE;
			interrupt_enable_reg_r <= timer01_pkg::RST_BYTE;
		end else begin
			timer_clock_select_r   <= timer_clock_select_nxt;
			timer01_control_reg_r  <= timer01_control_reg_nxt;
			timer01_mode_reg_r     <= timer01_mode_reg_nxt;
			timer0_lower_byte_r    <= timer0_lower_byte_nxt;
			timer0_upper_byte_r    <= timer0_upper_byte_nxt;
			timer1_lower_byte_r    <= timer1_lower_byte_nxt;
			timer1_upper_byte_r    <= timer1_upper_byte_nxt;
			ext_irq_config_reg_r   <= ext_irq_config_reg_nxt;
			interrupt_enable_reg_r <= interrupt_enable_reg_nxt;
		end
	end

	// outputs; requests lag the flag by one cycle, a cost of registering them
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rd_data_r      <= timer01_pkg::RST_BYTE;
			timer0_irq_r   <= 1'b0;
			timer1_irq_r   <= 1'b0;
			timer0_pulse_r <= 1'b0;
			timer1_pulse_r <= 1'b0;
		end else begin
			rd_data_r      <= reg_rd_i ? rd_data_nxt : timer01_pkg::RST_BYTE;
			timer0_irq_r   <= timer01_control_reg_r[timer01_pkg::BIT_T0_FLAG] &
			                  interrupt_enable_reg_r[timer01_pkg::BIT_T0_IRQ_EN];
			timer1_irq_r   <= timer01_control_reg_r[timer01_pkg::BIT_T1_FLAG] &
			                  interrupt_enable_reg_r[timer01_pkg::BIT_T1_IRQ_EN];
			timer0_pulse_r <= timer0_ovf;
			timer1_pulse_r <= timer1_ovf;
		end
	end

	assign reg_rd_data_o           = rd_data_r;
	assign timer0_irq_o            = timer0_irq_r;
	assign timer1_irq_o            = timer1_irq_r;
	assign timer0_overflow_pulse_o = timer0_pulse_r;
	assign timer1_overflow_pulse_o = timer1_pulse_r;

endmodule // dual_legacy_counter_timers

/* rtl/timer01_pkg.sv */
package timer01_pkg;

	// ------------------------------------------------------------
	// bus widths and register offsets
	// ------------------------------------------------------------
	localparam int            ADDR_W             = 4;
	localparam int            DATA_W             = 8;
	localparam logic [3:0]    OFS_CLOCK_SELECT   = 4'h0;
	localparam logic [3:0]    OFS_CONTROL        = 4'h1;
	localparam logic [3:0]    OFS_MODE           = 4'h2;
	localparam logic [3:0]    OFS_T0_LOWER       = 4'h3;
	localparam logic [3:0]    OFS_T0_UPPER       = 4'h4;
	localparam logic [3:0]    OFS_T1_LOWER       = 4'h5;
	localparam logic [3:0]    OFS_T1_UPPER       = 4'h6;
	localparam logic [3:0]    OFS_IRQ_CONFIG     = 4'h7;
	localparam logic [3:0]    OFS_IRQ_ENABLE     = 4'h8;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int            BIT_T1_SYSCLK      = 3;
	localparam int            BIT_T0_SYSCLK      = 2;
	localparam int            DIV_SEL_LSB        = 0;
	localparam int            BIT_T1_FLAG        = 7;
	localparam int            BIT_T1_RUN         = 6;
	localparam int            BIT_T0_FLAG        = 5;
	localparam int            BIT_T0_RUN         = 4;
	localparam int            BIT_T1_GATING      = 7;
	localparam int            BIT_T1_EDGE        = 6;
	localparam int            T1_MODE_LSB        = 4;
	localparam int            BIT_T0_GATING      = 3;
	localparam int            BIT_T0_EDGE        = 2;
	localparam int            T0_MODE_LSB        = 0;
	localparam int            BIT_IRQ_B_POL      = 7;
	localparam int            BIT_IRQ_A_POL      = 3;
	localparam int            BIT_T1_IRQ_EN      = 3;
	localparam int            BIT_T0_IRQ_EN      = 1;
	localparam logic [7:0]    IRQ_CONFIG_MASK    = 8'h88;
	localparam logic [7:0]    IRQ_ENABLE_MASK    = 8'h0a;
	localparam logic [7:0]    RST_BYTE           = 8'h00;

	// ------------------------------------------------------------
	// modes and divider choices
	// ------------------------------------------------------------
	localparam logic [1:0]    MODE_13BIT         = 2'h0;
	localparam logic [1:0]    MODE_16BIT         = 2'h1;
	localparam logic [1:0]    MODE_RELOAD        = 2'h2;
	localparam logic [1:0]    MODE_SPLIT         = 2'h3;
	localparam logic [1:0]    DIV_SEL_12         = 2'h0;
	localparam logic [1:0]    DIV_SEL_4          = 2'h1;
	localparam logic [1:0]    DIV_SEL_48         = 2'h2;
	localparam logic [1:0]    DIV_SEL_EXT        = 2'h3;
	localparam logic [5:0]    DIV_COUNT_12       = 6'h0c;
	localparam logic [5:0]    DIV_COUNT_4        = 6'h04;
	localparam logic [5:0]    DIV_COUNT_48       = 6'h30;
	localparam logic [5:0]    DIV_COUNT_EXT      = 6'h08;

endpackage

/* rtl/pin_edge_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser with edge pulses taken after the second stage
module pin_edge_sync (
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      fall_o,
	output logic      rise_o
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// first stage feeds only the second; edges compare stages two and three
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign fall_o  = last_r & ~sync_r;
	assign rise_o  = sync_r & ~last_r;
endmodule // pin_edge_sync

/* rtl/timer_prescaler.sv */
`timescale 1ns/1ns
// shared prescaler: one-cycle tick per divided period
module timer_prescaler #(
	parameter int CNT_W = 6
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [1:0] div_sel_i,
	input  wire logic       osc_edge_i,
	output logic            tick_o
);
	logic [CNT_W-1:0] cnt_r;
	logic             tick_r;
	wire  [CNT_W-1:0] limit;
	wire              advance;
	wire              wrap;

	// divisor choice; the oscillator path counts its synchronised edges
	assign limit   = (div_sel_i == timer01_pkg::DIV_SEL_12) ? timer01_pkg::DIV_COUNT_12 :
	                 (div_sel_i == timer01_pkg::DIV_SEL_4)  ? timer01_pkg::DIV_COUNT_4  :
	                 (div_sel_i == timer01_pkg::DIV_SEL_48) ? timer01_pkg::DIV_COUNT_48 :
	                 timer01_pkg::DIV_COUNT_EXT;
	assign advance = (div_sel_i == timer01_pkg::DIV_SEL_EXT) ? osc_edge_i : 1'b1;
	// >= so a shrinking divisor never strands the counter above it
	assign wrap    = advance && (cnt_r >= limit - {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= wrap ? '0 : (advance ? cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_r);
			tick_r <= wrap;
		end
	end

	assign tick_o = tick_r;
endmodule // timer_prescaler

/* tb/timer01_assertions.sv */
`timescale 1ns/1ns
// watches register readback and timer outputs at the top ports
module timer01_chk (
	input wire logic       sys_clk_i,
	input wire logic       rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wr_data_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rd_data_o,
	input wire logic       timer0_irq_o,
	input wire logic       timer1_irq_o,
	input wire logic       timer0_overflow_pulse_o
);
	logic [7:0] mode_r;
	logic [7:0] en_r;
	logic       run_r;
	// shadows of software-only bits; hardware never writes these
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mode_r <= 8'h00;
			en_r <= 8'h00;
			run_r <= 1'b0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 4'h2) mode_r <= reg_wr_data_i;
			if (reg_addr_i == 4'h8) en_r <= reg_wr_data_i;
			if (reg_addr_i == 4'h1) run_r <= reg_wr_data_i[4];
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rd_data_o == 8'h00)
		else $error("read data outside slot");
	mode_rb_a: assert property ($past(reg_rd_i && reg_addr_i == 4'h2) |->
		reg_rd_data_o == $past(mode_r)) else $error("mode readback");
	cfg_rsvd_a: assert property ($past(reg_rd_i && reg_addr_i == 4'h7) |->
		(reg_rd_data_o & 8'h77) == 8'h00) else $error("config spare bits");
	en_rsvd_a: assert property ($past(reg_rd_i && reg_addr_i == 4'h8) |->
		(reg_rd_data_o & 8'hf5) == 8'h00) else $error("enable spare bits");
	hole_rd_a: assert property ($past(reg_rd_i && reg_addr_i > 4'h8) |->
		reg_rd_data_o == 8'h00) else $error("hole read");
	irq0_en_a: assert property (timer0_irq_o |-> $past(en_r[1]))
		else $error("irq0 without enable");
	irq1_en_a: assert property (timer1_irq_o |-> $past(en_r[3]))
		else $error("irq1 without enable");
	pulse_run_a: assert property (timer0_overflow_pulse_o |-> $past(run_r) || $past(run_r, 2))
		else $error("pulse while stopped");
	cover property (timer0_irq_o);
	cover property (timer1_irq_o);
	cover property (timer0_overflow_pulse_o && run_r);
endmodule // timer01_chk

bind dual_legacy_counter_timers timer01_chk i_timer01_chk (.sys_clk_i, .rst_b_i, .reg_addr_i,
	.reg_wr_data_i, .reg_wr_i, .reg_rd_i, .reg_rd_data_o, .timer0_irq_o, .timer1_irq_o,
	.timer0_overflow_pulse_o);

/* tb/pin_partner.sv */
`timescale 1ns/1ns
// far side: count pins and a free oscillator, all well below half the clock
module pin_partner (
	input  wire logic sys_clk_i,
	input  wire logic run_i,
	output logic      pin0_o,
	output logic      pin1_o,
	output logic      osc_o
);
	logic [2:0] ph_r = 3'h0;
	initial {pin0_o, pin1_o, osc_o} = 3'b110;
	// six-clock cycle, three low and three high; idle pins rest high
	always @(posedge sys_clk_i) begin
		ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
		pin0_o <= !(run_i && ph_r < 3'h3);
		pin1_o <= !(run_i && ph_r > 3'h2);
		osc_o <= ph_r < 3'h3;
	end
endmodule // pin_partner

/* tb/dual_legacy_counter_timers_tb.sv */
`timescale 1ns/1ns
module dual_legacy_counter_timers_tb;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        ga = 1'b1;
	logic        gb = 1'b0;
	logic        prun = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wd = 8'h00;
	logic [7:0]  rdata;
	logic [31:0] lf = 32'h00011563;
	logic [3:0]  ra [5] = '{4'h0, 4'h2, 4'h7, 4'h8, 4'hf};
	wire         p0, p1, osc, i0, i1, o0, o1;
	wire  [3:0]  obs = {i1, i0, o1, o0};
	int          num_errors = 0;
	int          samples_checked = 0;
	int          n;
	dual_legacy_counter_timers i_dual_legacy_counter_timers (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
		.reg_addr_i(addr), .reg_wr_data_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rd_data_o(rdata),
		.timer0_count_pin_i(p0), .timer1_count_pin_i(p1), .ext_irq_input_a_i(ga),
		.ext_irq_input_b_i(gb), .ext_osc_i(osc), .timer0_irq_o(i0), .timer1_irq_o(i1),
		.timer0_overflow_pulse_o(o0), .timer1_overflow_pulse_o(o1));
	pin_partner i_pin_partner (.sys_clk_i(sys_clk), .run_i(prun), .pin0_o(p0), .pin1_o(p1), .osc_o(osc));
	initial forever #5 sys_clk = ~sys_clk;
	// bench arithmetic: random source and expected values
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] rb_exp(input logic [3:0] a, input logic [7:0] d);
		if (a == 4'h7) return d & timer01_pkg::IRQ_CONFIG_MASK;
		if (a == 4'h8) return d & timer01_pkg::IRQ_ENABLE_MASK;
		return (a > 4'h8) ? 8'h00 : d;
	endfunction
	function automatic logic [7:0] div_exp(input logic [1:0] s);
		return (s == 2'h1) ? 8'h04 : (s == 2'h0) ? 8'h0c : 8'h30;
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// bus cycles: one-cycle strobes, read data taken in the following cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		we <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge sys_clk);
		we <= 1'b0;
	endtask
	task automatic prog(input logic [11:0] q[$]);
		foreach (q[k]) wr(q[k][11:8], q[k][7:0]);
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge sys_clk);
		re <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		re <= 1'b0;
		@(negedge sys_clk);
		chk($sformatf("reg%h", a), e, rdata & m);
	endtask
	// bounded wait for an output; returns spacing in cycles
	task automatic wt(input int b, output int c);
		c = 1;
		@(negedge sys_clk);
		while (obs[b] !== 1'b1) begin
			@(negedge sys_clk);
			c++;
			if (c > 3000) begin
				num_errors++;
				test_done();
			end
		end
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 16; a++) rc(a[3:0], 8'h00, 8'hff);
		// random readback of storage, spare bits and holes
		repeat (8) begin
			lf = nxt(lf);
			@(posedge sys_clk) gb <= lf[9];
			wr(ra[lf[10:8] % 3'h5], lf[7:0]);
			rc(ra[lf[10:8] % 3'h5], rb_exp(ra[lf[10:8] % 3'h5], lf[7:0]), 8'hff);
		end
		// 13-bit pin counting: wrap clears upper byte and raises flag
		prog('{12'h700, 12'h204, 12'h4ff, 12'h31f, 12'h802, 12'h110});
		prun <= 1'b1;
		wt(0, n);
		@(posedge sys_clk) prun <= 1'b0;
		rc(4'h4, 8'h00, 8'hff);
		rc(4'h1, 8'h30, 8'hff);
		wt(2, n);
		prog('{12'h100});
		repeat (3) @(negedge sys_clk);
		chk("irq0", 8'h00, {7'h00, i0});
		// closed gate holds a preloaded count, open gate lets it wrap
		prog('{12'h004, 12'h209, 12'h3ff, 12'h4ff, 12'h110});
		repeat (20) @(negedge sys_clk);
		rc(4'h3, 8'hff, 8'hff);
		@(posedge sys_clk) ga <= 1'b0;
		wt(0, n);
		rc(4'h4, 8'h00, 8'hff);
		// reload overflow spacing equals the prescaler ratio
		prog('{12'h202, 12'h4ff, 12'h3ff, 12'h110});
		for (int s = 0; s < 4; s++) begin
			wr(4'h0, s[7:0]);
			// up to two stale pulses and one odd first tick after a divider change
			repeat (4) wt(0, n);
			chk("period", div_exp(s[1:0]), n[7:0]);
		end
		rc(4'h4, 8'hff, 8'hff);
		// split mode: upper byte runs on timer 1 run bit and flag
		prog('{12'h100, 12'h300, 12'h203, 12'h808, 12'h140});
		wt(3, n);
		rc(4'h1, 8'hc0, 8'hdf);
		rc(4'h3, 8'h00, 8'hff);
		// split: timer 1 reload on the system clock pulses but never flags
		prog('{12'h008, 12'h223, 12'h6ff, 12'h5ff, 12'h140});
		wt(1, n);
		rc(4'h1, 8'h40, 8'hff);
		// timer 1 still on the system clock, so a missed park shows at once
		prog('{12'h233, 12'h500});
		repeat (20) @(negedge sys_clk);
		rc(4'h5, 8'h00, 8'hff);
		test_done();
	end
endmodule // dual_legacy_counter_timers_tb
